//--- rtl/fault_status_pkg.sv
// Functional notes
// - Read-only 32-bit fault register at E2h, zero at reset, no writes.
// - Bit 31 is the OR of every individual fault flag.
// - Position detect frequency, time1 and time2 faults at bits 29, 28, 27.
// - Bit 26 shows whether the supply bus current limit is active now.
// - Bit 25 flags R/L measure error, bit 24 back-EMF constant error.
// - Bits 23, 22, 21 speed, back-EMF, absent motor; bit 20 any lock.
// - Bit 19 lock current limit fault, bit 18 hardware current limit fault.
// - Bit 17 bus undervoltage fault, bit 16 bus overvoltage fault.
// - Bits 15, 14 speed and current loop saturation; bits 13 to 4 zero.
// - Host sets refresh bit every watchdog interval; device clears it.
package fault_status_pkg;

   localparam logic [7:0] FAULT_REG_ADDR = 8'hE2;
   localparam logic [7:0] CTRL_REG_ADDR = 8'hEA;
   localparam logic [31:0] FAULT_RESET = 32'h0000_0000;
   localparam logic [31:0] STICKY_MASK = 32'h3BFF_0008;
   localparam logic [31:0] LIVE_MASK = 32'h0400_C000;
   localparam logic [15:0] WDT_CNT_RESET = 16'h0000;

   localparam int SUMMARY_BIT = 31;
   localparam int FREQ_BIT = 29;
   localparam int TIME1_BIT = 28;
   localparam int TIME2_BIT = 27;
   localparam int BUS_LIMIT_BIT = 26;
   localparam int RL_BIT = 25;
   localparam int BEMF_CONST_BIT = 24;
   localparam int SPEED_LOCK_BIT = 23;
   localparam int BEMF_LOCK_BIT = 22;
   localparam int ABSENT_BIT = 21;
   localparam int ANY_LOCK_BIT = 20;
   localparam int LOCK_LIMIT_BIT = 19;
   localparam int HW_LIMIT_BIT = 18;
   localparam int UNDERVOLT_BIT = 17;
   localparam int OVERVOLT_BIT = 16;
   localparam int SPEED_SAT_BIT = 15;
   localparam int CURRENT_SAT_BIT = 14;
   localparam int WDT_FAULT_BIT = 3;

   localparam int CLEAR_CMD_BIT = 29;
   localparam int REFRESH_BIT = 10;

   typedef struct packed {
      logic [31:0] flags;
   } flag_state_t;

   typedef struct packed {
      logic [31:0] live;
      logic refresh;
      logic [15:0] wdt_cnt;
      logic wdt_trip;
      logic [31:0] rdata;
      logic rvalid;
   } core_state_t;

endpackage

//--- rtl/sticky_flags.sv
`timescale 1ns/1ps
module sticky_flags #(
   parameter int W = 32
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [W-1:0] set_vec,
   input wire logic clear,
   output logic [W-1:0] flags
);
   import fault_status_pkg::*;

   logic [W-1:0] state_ff;
   logic [W-1:0] nxt_state;

   // Set wins over a clear in the same cycle
   always_comb begin
      nxt_state = (state_ff & {W{~clear}}) | set_vec;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign flags = state_ff;

   set_hold_a: assert property (
      @(posedge clk) disable iff (!rstn)
      (set_vec != '0) |=> ((flags & $past(set_vec)) == $past(set_vec)))
      else $error("set flag not captured");

   hold_no_clear_a: assert property (
      @(posedge clk) disable iff (!rstn)
      !clear |=> ((flags & $past(flags)) == $past(flags)))
      else $error("flag dropped without clear");

endmodule

//--- rtl/controller_fault_status_reg.sv
`timescale 1ns/1ps
module controller_fault_status_reg (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic reg_wr,
   input wire logic [31:0] reg_wdata,
   output logic [31:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic position_detect_freq_err,
   input wire logic position_detect_time1_err,
   input wire logic position_detect_time2_err,
   input wire logic bus_current_limit_active,
   input wire logic rl_measure_err,
   input wire logic backemf_const_measure_err,
   input wire logic abnormal_speed_lock,
   input wire logic abnormal_backemf_lock,
   input wire logic motor_absent,
   input wire logic lock_current_limit_err,
   input wire logic hardware_current_limit_err,
   input wire logic bus_undervolt,
   input wire logic bus_overvolt,
   input wire logic speed_loop_sat,
   input wire logic current_loop_sat,
   input wire logic wdt_enable,
   input wire logic [15:0] wdt_interval,
   output logic watchdog_refresh
);
   import fault_status_pkg::*;

   core_state_t st_ff;
   core_state_t nxt_st;
   logic [31:0] set_vec;
   logic [31:0] sticky;
   logic [31:0] image;
   logic any_motor_lock;
   logic ctrl_wr;
   logic clear_all_faults;

   ////////////////////////////////////////////////////////////////////////
   // Fault capture

   assign any_motor_lock = abnormal_speed_lock | abnormal_backemf_lock |
      motor_absent | lock_current_limit_err |
      hardware_current_limit_err;
   assign ctrl_wr = reg_wr && (reg_addr == CTRL_REG_ADDR);
   assign clear_all_faults = ctrl_wr && reg_wdata[CLEAR_CMD_BIT];

   always_comb begin
      set_vec = '0;
      set_vec[FREQ_BIT] = position_detect_freq_err;
      set_vec[TIME1_BIT] = position_detect_time1_err;
      set_vec[TIME2_BIT] = position_detect_time2_err;
      set_vec[RL_BIT] = rl_measure_err;
      set_vec[BEMF_CONST_BIT] = backemf_const_measure_err;
      set_vec[SPEED_LOCK_BIT] = abnormal_speed_lock;
      set_vec[BEMF_LOCK_BIT] = abnormal_backemf_lock;
      set_vec[ABSENT_BIT] = motor_absent;
      set_vec[ANY_LOCK_BIT] = any_motor_lock;
      set_vec[LOCK_LIMIT_BIT] = lock_current_limit_err;
      set_vec[HW_LIMIT_BIT] = hardware_current_limit_err;
      set_vec[UNDERVOLT_BIT] = bus_undervolt;
      set_vec[OVERVOLT_BIT] = bus_overvolt;
      set_vec[WDT_FAULT_BIT] = st_ff.wdt_trip;
   end

   sticky_flags #(
      .W(32)
   ) u_flags (
      .clk(clk),
      .rstn(rstn),
      .set_vec(set_vec),
      .clear(clear_all_faults),
      .flags(sticky)
   );

   // Reserved bits are masked to zero; bit 31 summarises the rest
   always_comb begin
      image = (sticky & STICKY_MASK) | (st_ff.live & LIVE_MASK);
      image[SUMMARY_BIT] = |image[30:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // Live status, watchdog and register port

   always_comb begin
      nxt_st = st_ff;
      nxt_st.live = '0;
      nxt_st.live[BUS_LIMIT_BIT] = bus_current_limit_active;
      nxt_st.live[SPEED_SAT_BIT] = speed_loop_sat;
      nxt_st.live[CURRENT_SAT_BIT] = current_loop_sat;
      // Refresh bit lives one cycle, then the device clears it
      nxt_st.refresh = ctrl_wr && reg_wdata[REFRESH_BIT];
      nxt_st.wdt_trip = 1'b0;
      if (!wdt_enable || st_ff.refresh) begin
         nxt_st.wdt_cnt = WDT_CNT_RESET;
      end else if (st_ff.wdt_cnt >= wdt_interval) begin
         nxt_st.wdt_cnt = WDT_CNT_RESET;
         nxt_st.wdt_trip = 1'b1;
      end else begin
         nxt_st.wdt_cnt = st_ff.wdt_cnt + 16'h0001;
      end
      // Writes to the fault register are dropped
      nxt_st.rvalid = reg_rd;
      if (reg_rd) begin
         if (reg_addr == FAULT_REG_ADDR) begin
            nxt_st.rdata = image;
         end else if (reg_addr == CTRL_REG_ADDR) begin
            nxt_st.rdata = 32'h0000_0000;
            nxt_st.rdata[REFRESH_BIT] = st_ff.refresh;
         end else begin
            nxt_st.rdata = 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= '{live: FAULT_RESET, refresh: 1'b0,
            wdt_cnt: WDT_CNT_RESET, wdt_trip: 1'b0,
            rdata: FAULT_RESET, rvalid: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata = st_ff.rdata;
   assign reg_rvalid = st_ff.rvalid;
   assign watchdog_refresh = st_ff.refresh;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   sequence fault_read_s;
      reg_rd && (reg_addr == FAULT_REG_ADDR);
   endsequence

   sequence clear_quiet_s;
      clear_all_faults && (set_vec == 32'h0000_0000);
   endsequence

   summary_or_a: assert property (
      image[SUMMARY_BIT] == ((sticky & STICKY_MASK) != 32'h0000_0000 ||
      (st_ff.live & LIVE_MASK) != 32'h0000_0000))
      else $error("summary bit differs from flag OR");

   reserved_zero_a: assert property (
      image[13:4] == 10'h000 && image[2:0] == 3'h0 && !image[30])
      else $error("reserved bit reads one");

   read_image_a: assert property (
      fault_read_s |=> reg_rvalid && reg_rdata == $past(image))
      else $error("fault read returned wrong data");

   write_ignored_a: assert property (
      reg_wr && (reg_addr == FAULT_REG_ADDR) && !clear_all_faults
      |=> (sticky & STICKY_MASK) ==
      (($past(sticky) | $past(set_vec)) & STICKY_MASK))
      else $error("write altered fault flags");

   freq_flag_a: assert property (
      position_detect_freq_err |=> image[FREQ_BIT] ##1 image[FREQ_BIT]
      || $past(clear_all_faults))
      else $error("frequency fault not held");

   bus_limit_live_a: assert property (
      1'b1 |=> image[BUS_LIMIT_BIT] == $past(bus_current_limit_active))
      else $error("bus limit status not tracking");

   rl_flag_a: assert property (
      rl_measure_err |=> image[RL_BIT] && image[SUMMARY_BIT])
      else $error("measure fault not flagged");

   any_lock_a: assert property (
      any_motor_lock |=> image[ANY_LOCK_BIT])
      else $error("motor lock summary not set");

   hw_limit_a: assert property (
      hardware_current_limit_err |=> image[HW_LIMIT_BIT] &&
      image[ANY_LOCK_BIT])
      else $error("hardware limit not flagged");

   undervolt_a: assert property (
      bus_undervolt |=> image[UNDERVOLT_BIT])
      else $error("undervoltage not flagged");

   wdt_fault_a: assert property (
      wdt_enable && !st_ff.refresh && !ctrl_wr &&
      st_ff.wdt_cnt >= wdt_interval |=> ##1 image[WDT_FAULT_BIT])
      else $error("watchdog timeout not flagged");

   refresh_clear_a: assert property (
      watchdog_refresh && !ctrl_wr |=> !watchdog_refresh &&
      st_ff.wdt_cnt == WDT_CNT_RESET)
      else $error("refresh bit not self-cleared");

   clear_all_a: assert property (
      clear_quiet_s |=> (image & STICKY_MASK) == 32'h0000_0000)
      else $error("clear left a flag set");

   time1_flag_a: assert property (
      position_detect_time1_err |=> image[TIME1_BIT])
      else $error("time1 fault not flagged");

   time2_flag_a: assert property (
      position_detect_time2_err |=> image[TIME2_BIT])
      else $error("time2 fault not flagged");

   bemf_const_a: assert property (
      backemf_const_measure_err |=> image[BEMF_CONST_BIT] &&
      image[SUMMARY_BIT])
      else $error("constant measure fault not flagged");

   speed_lock_a: assert property (
      abnormal_speed_lock |=> image[SPEED_LOCK_BIT] && image[ANY_LOCK_BIT])
      else $error("speed lock not flagged");

   bemf_lock_a: assert property (
      abnormal_backemf_lock |=> image[BEMF_LOCK_BIT] && image[ANY_LOCK_BIT])
      else $error("back-EMF lock not flagged");

   absent_flag_a: assert property (
      motor_absent |=> image[ABSENT_BIT] && image[ANY_LOCK_BIT])
      else $error("absent motor not flagged");

   lock_limit_a: assert property (
      lock_current_limit_err |=> image[LOCK_LIMIT_BIT] &&
      image[ANY_LOCK_BIT])
      else $error("lock limit not flagged");

   overvolt_a: assert property (
      bus_overvolt |=> image[OVERVOLT_BIT])
      else $error("overvoltage not flagged");

   loop_sat_live_a: assert property (
      1'b1 |=> image[SPEED_SAT_BIT] == $past(speed_loop_sat) &&
      image[CURRENT_SAT_BIT] == $past(current_loop_sat))
      else $error("loop saturation not tracking");

   refresh_set_a: assert property (
      ctrl_wr && reg_wdata[REFRESH_BIT] |=> watchdog_refresh)
      else $error("refresh write not taken");

endmodule

//--- tb/host_model.sv
`timescale 1ns/1ps
module host_model (
   input wire logic clk,
   output logic [7:0] reg_addr,
   output logic reg_rd,
   output logic reg_wr,
   output logic [31:0] reg_wdata
);
   initial begin
      reg_addr = 8'h00;
      reg_rd = 1'b0;
      reg_wr = 1'b0;
      reg_wdata = 32'h0000_0000;
   end
   // One-cycle read strobe; the address is scrambled once released
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
   endtask
   // One-cycle write strobe; refresh writes come from here
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
endmodule

//--- tb/tb.sv
`timescale 1ns/1ps
module tb;
   import fault_status_pkg::*;
   logic clk, rstn, rd, wr, rvalid, wdt_en, refresh;
   logic [7:0] addr;
   logic [31:0] wdata, rdata;
   logic [14:0] ev, v;
   logic [15:0] seed;
   logic [31:0] q[$];
   int fail_count = 0, check_count = 0, cyc = 0, pulses = 0;
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   host_model host (.clk(clk), .reg_addr(addr), .reg_rd(rd), .reg_wr(wr),
      .reg_wdata(wdata));
   controller_fault_status_reg dut (.clk(clk), .rstn(rstn),
      .reg_addr(addr), .reg_rd(rd), .reg_wr(wr), .reg_wdata(wdata),
      .reg_rdata(rdata), .reg_rvalid(rvalid),
      .position_detect_freq_err(ev[0]), .position_detect_time1_err(ev[1]),
      .position_detect_time2_err(ev[2]), .bus_current_limit_active(ev[3]),
      .rl_measure_err(ev[4]), .backemf_const_measure_err(ev[5]),
      .abnormal_speed_lock(ev[6]), .abnormal_backemf_lock(ev[7]),
      .motor_absent(ev[8]), .lock_current_limit_err(ev[9]),
      .hardware_current_limit_err(ev[10]), .bus_undervolt(ev[11]),
      .bus_overvolt(ev[12]), .speed_loop_sat(ev[13]),
      .current_loop_sat(ev[14]), .wdt_enable(wdt_en),
      .wdt_interval(16'h0014), .watchdog_refresh(refresh));
   ////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   function automatic logic [31:0] expv(input logic [14:0] s);
      int pos [15] = '{29, 28, 27, 26, 25, 24, 23, 22, 21, 19, 18, 17, 16,
         15, 14};
      logic [31:0] e;
      e = 32'h0000_0000;
      for (int k = 0; k < 15; k++) begin
         if (s[k]) e[pos[k]] = 1'b1;
      end
      e[20] = |s[10:6];
      e[31] = |e;
      return e;
   endfunction
   task automatic read(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      host.rd(a);
   endtask
   task automatic clear_all;
      host.wr(8'hEA, 32'h2000_0000);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fail_count++;
         results();
      end
      if (refresh === 1'b1) pulses <= pulses + 1;
      if (rvalid === 1'b1) begin
         check_count++;
         if (q.size() == 0) begin
            $display("unexpected reg_rvalid exp 0 got 1");
            fail_count++;
         end else begin
            if (rdata !== q[0]) begin
               $display("unexpected reg_rdata exp %h got %h", q[0], rdata);
               fail_count++;
            end
            void'(q.pop_front());
         end
      end
   end
   initial begin
      rstn = 1'b0;
      ev = 15'h0000;
      wdt_en = 1'b0;
      seed = 16'h2608;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      read(8'hE2, 32'h0000_0000);
      host.wr(8'hE2, 32'hFFFF_FFFF);
      read(8'hE2, 32'h0000_0000);
      read(8'h55, 32'h0000_0000);
      read(8'hEA, 32'h0000_0000);
      for (int i = 0; i < 23; i++) begin
         seed = lfsr(seed);
         v = (i < 15) ? (15'h0001 << i) : seed[14:0];
         @(posedge clk);
         ev <= v;
         read(8'hE2, expv(v));
         ev <= 15'h0000;
         clear_all();
         read(8'hE2, 32'h0000_0000);
      end
      @(posedge clk);
      ev <= 15'h7FFF;
      repeat (2) @(posedge clk);
      ev <= 15'h0000;
      rstn <= 1'b0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      read(8'hE2, 32'h0000_0000);
      @(posedge clk);
      wdt_en <= 1'b1;
      repeat (5) begin
         repeat (10) @(posedge clk);
         host.wr(8'hEA, 32'h0000_0400);
      end
      read(8'hE2, 32'h0000_0000);
      repeat (30) @(posedge clk);
      read(8'hE2, 32'h8000_0008);
      wdt_en <= 1'b0;
      clear_all();
      read(8'hE2, 32'h0000_0000);
      repeat (4) @(posedge clk);
      check_count++;
      if (pulses != 5) begin
         $display("unexpected watchdog_refresh exp 5 got %0d", pulses);
         fail_count++;
      end
      check_count++;
      if (q.size() != 0) begin
         $display("unexpected pending_reads exp 0 got %0d", q.size());
         fail_count++;
      end
      results();
   end
endmodule
